// *** pkg/bnvr_pkg.sv ***
package bnvr_pkg;
   // Array geometry
   localparam int ADDR_W = 13;
   localparam int DATA_W = 8;
   localparam int ROW_BYTES_LOG2 = 3;
   // Controller clock period in picoseconds
   localparam int CLK_PERIOD_PS = 4000;
   // Bus timing in nanoseconds
   localparam int ACCESS_NS = 70;
   localparam int PRECHARGE_NS = 60;
   localparam int SEL_LOW_MAX_NS = 10000;
   // Least times round up, longest rounds down
   localparam int ACCESS_CYC = (ACCESS_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int PRECHARGE_CYC = (PRECHARGE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int SEL_LOW_MAX_CYC = (SEL_LOW_MAX_NS * 1000) / CLK_PERIOD_PS;
   localparam int CNT_W = 16;
   // Data setup before the write strobe rises
   localparam int WR_SETUP_CYC = 1;
   // Host controller states
   typedef enum logic [2:0] {
      BNVR_IDLE,
      BNVR_SETUP,
      BNVR_ACCESS,
      BNVR_PRECHARGE
   } bnvr_state_t;
endpackage

// *** verilog/bnvr_host.sv ***
`timescale 1ns/100ps
// Operation
// - Host holds strobes low for access time and data stable before end.
// - Writes complete in bus cycle; next access may follow immediately.
// - Host holds select high at least precharge time between cycles.
// - Host keeps select low no longer than maximum low time; the cap counts only cycles with clk_en high.
// - Every access starts with a fresh select falling edge.
// - Select stays high during power transitions and reset.
// - Write strobe stays high whenever not writing, including power events.
module bnvr_host #(
   parameter int ACCESS_CYC = bnvr_pkg::ACCESS_CYC,           // Access time in cycles
   parameter int PRECHARGE_CYC = bnvr_pkg::PRECHARGE_CYC,     // Precharge in cycles
   parameter int SEL_LOW_MAX_CYC = bnvr_pkg::SEL_LOW_MAX_CYC  // Longest select low
) (
   input wire logic clock,                                 // Controller clock
   input wire logic rst,                                   // Async reset, active high
   input wire logic clk_en,                                // Clock enable
   input wire logic req_valid,                             // Access request
   input wire logic req_write,                             // 1 write, 0 read
   input wire logic [bnvr_pkg::ADDR_W-1:0] req_addr,       // Byte address
   input wire logic [bnvr_pkg::DATA_W-1:0] req_wdata,      // Write data
   output logic req_ready,                                 // Request accepted
   output logic rsp_valid,                                 // Access done pulse
   output logic [bnvr_pkg::DATA_W-1:0] rsp_rdata,          // Read data
   output logic [bnvr_pkg::CNT_W-1:0] row_access_count,    // Row endurance cycles used
   output logic [bnvr_pkg::ADDR_W-bnvr_pkg::ROW_BYTES_LOG2-1:0] last_row, // Row of last access
   output logic sel_n,                                     // Select strobe, active low
   output logic wr_n,                                      // Write strobe, active low
   output logic oe_n,                                      // Output enable, active low
   output logic [bnvr_pkg::ADDR_W-1:0] byte_address_lines, // Address pins
   output logic [bnvr_pkg::DATA_W-1:0] byte_data_lines_o,  // Data pins out
   output logic byte_data_lines_oe,                        // Data pins drive enable
   input wire logic [bnvr_pkg::DATA_W-1:0] byte_data_lines_i // Data pins in
);
   localparam int ROW_W = bnvr_pkg::ADDR_W - bnvr_pkg::ROW_BYTES_LOG2;
   localparam logic [bnvr_pkg::CNT_W-1:0] ACC_LAST = bnvr_pkg::CNT_W'(ACCESS_CYC - 1);
   localparam logic [bnvr_pkg::CNT_W-1:0] PRE_LAST = bnvr_pkg::CNT_W'(PRECHARGE_CYC - 1);
   localparam logic [bnvr_pkg::CNT_W-1:0] LOW_LAST = bnvr_pkg::CNT_W'(SEL_LOW_MAX_CYC - 1);
   localparam logic [bnvr_pkg::CNT_W-1:0] CNT_ONE = bnvr_pkg::CNT_W'(1);

   bnvr_pkg::bnvr_state_t state_q;
   logic [bnvr_pkg::CNT_W-1:0] cnt_q;
   logic write_q;

   // Decoded conditions shared by the processes
   logic take_req; // Request taken at this edge
   logic acc_time_met; // Access time satisfied
   logic sel_low_cap; // Select-low limit reached
   logic acc_end; // Last cycle of select low
   logic pre_end; // Last cycle of precharge
   logic rd_capture; // Read data sampled at this edge
   logic [ROW_W-1:0] addr_row; // Row of the driven address

   // Request taken only in idle
   assign take_req = (state_q == bnvr_pkg::BNVR_IDLE) && req_valid;

   assign acc_time_met = cnt_q >= ACC_LAST;

   assign sel_low_cap = cnt_q >= LOW_LAST;

   // Access ends on either; a short cap truncates the access
   assign acc_end = acc_time_met || sel_low_cap;

   assign pre_end = cnt_q >= PRE_LAST;

   assign rd_capture = (state_q == bnvr_pkg::BNVR_ACCESS) && acc_end && !write_q;

   assign addr_row = byte_address_lines[bnvr_pkg::ADDR_W-1:bnvr_pkg::ROW_BYTES_LOG2];

   // Sequencer for one access plus precharge
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         state_q <= bnvr_pkg::BNVR_IDLE;
         cnt_q <= '0;
         write_q <= 1'b0;
      end else if (clk_en) begin
         unique case (state_q)
            bnvr_pkg::BNVR_IDLE: begin
               cnt_q <= '0;
               if (req_valid) begin
                  write_q <= req_write;
                  state_q <= bnvr_pkg::BNVR_SETUP;
               end
            end
            bnvr_pkg::BNVR_SETUP: begin
               cnt_q <= '0;
               state_q <= bnvr_pkg::BNVR_ACCESS;
            end
            bnvr_pkg::BNVR_ACCESS: begin
               if (acc_end) begin
                  cnt_q <= '0;
                  state_q <= bnvr_pkg::BNVR_PRECHARGE;
               end else begin
                  cnt_q <= cnt_q + CNT_ONE;
               end
            end
            bnvr_pkg::BNVR_PRECHARGE: begin
               if (pre_end) begin
                  cnt_q <= '0;
                  state_q <= bnvr_pkg::BNVR_IDLE;
               end else begin
                  cnt_q <= cnt_q + CNT_ONE;
               end
            end
            default: state_q <= bnvr_pkg::BNVR_IDLE;
         endcase
      end
   end

   // Request handshake
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         req_ready <= 1'b0;
      end else if (clk_en) begin
         req_ready <= take_req;
      end
   end

   // Address held from take to the next take
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         byte_address_lines <= '0;
      end else if (clk_en && take_req) begin
         byte_address_lines <= req_addr;
      end
   end

   // Write data held through the strobe rise
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         byte_data_lines_o <= '0;
      end else if (clk_en && take_req) begin
         byte_data_lines_o <= req_wdata;
      end
   end

   // Strobes; all high in reset so no access can start
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         sel_n <= 1'b1;
         wr_n <= 1'b1;
         oe_n <= 1'b1;
         byte_data_lines_oe <= 1'b0;
      end else if (clk_en) begin
         unique case (state_q)
            bnvr_pkg::BNVR_IDLE: begin
               sel_n <= 1'b1;
               wr_n <= ~(req_valid && req_write);
               oe_n <= 1'b1;
               byte_data_lines_oe <= req_valid && req_write;
            end
            bnvr_pkg::BNVR_SETUP: begin
               sel_n <= 1'b0;
               oe_n <= write_q;
            end
            bnvr_pkg::BNVR_ACCESS: begin
               if (acc_end) begin
                  sel_n <= 1'b1;
                  wr_n <= 1'b1;
                  oe_n <= 1'b1;
               end
            end
            bnvr_pkg::BNVR_PRECHARGE: begin
               wr_n <= 1'b1;
               byte_data_lines_oe <= 1'b0;
            end
            default: sel_n <= 1'b1;
         endcase
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         rsp_valid <= 1'b0;
      end else if (clk_en) begin
         rsp_valid <= (state_q == bnvr_pkg::BNVR_ACCESS) && acc_end;
      end
   end

   // Read data held until the next read
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         rsp_rdata <= '0;
      end else if (clk_en && rd_capture) begin
         rsp_rdata <= byte_data_lines_i;
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         row_access_count <= '0;
      end else if (clk_en && state_q == bnvr_pkg::BNVR_SETUP) begin
         row_access_count <= row_access_count + CNT_ONE; // Wraps at full count
      end
   end

   // Row of the latest access, to spot hot rows
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         last_row <= '0;
      end else if (clk_en && state_q == bnvr_pkg::BNVR_SETUP) begin
         last_row <= addr_row;
      end
   end
endmodule

// *** verification/bnvr_checker.sv ***
`timescale 1ns/100ps
module bnvr_checker #(
   parameter int ACCESS_CYC = bnvr_pkg::ACCESS_CYC, // Select low
   parameter int PRECHARGE_CYC = bnvr_pkg::PRECHARGE_CYC, // Select high
   parameter int SEL_LOW_MAX_CYC = bnvr_pkg::SEL_LOW_MAX_CYC // Low cap
) (
   input wire logic clock, // Clock
   input wire logic rst, // Reset
   input wire logic clk_en, // Clock enable
   input wire logic req_ready, // Taken
   input wire logic sel_n, // Select
   input wire logic wr_n, // Write strobe
   input wire logic oe_n, // Output enable
   input wire logic byte_data_lines_oe // Host drives
);
   logic [15:0] lo_q, hi_q;
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   // Cycles with select low and high
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         lo_q <= '0;
      end else if (clk_en) begin
         lo_q <= sel_n ? '0 : lo_q + 16'h1;
      end
   end
   // Precharge counter starts satisfied after reset
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         hi_q <= 16'(PRECHARGE_CYC);
      end else if (clk_en) begin
         hi_q <= sel_n ? hi_q + 16'h1 : '0;
      end
   end
   // Strobe timing and order
   a_access_len: assert property ($rose(sel_n) |-> lo_q == 16'(ACCESS_CYC))
      else $error("select low time");
   a_precharge_len: assert property ($fell(sel_n) |-> hi_q >= 16'(PRECHARGE_CYC))
      else $error("precharge short");
   a_low_max: assert property (lo_q <= 16'(SEL_LOW_MAX_CYC))
      else $error("select low long");
   a_fresh_select: assert property (req_ready && clk_en |=> $fell(sel_n))
      else $error("no select fall");
   a_ce_write: assert property ($fell(wr_n) |=> $fell(sel_n))
      else $error("write strobe late");
   a_write_end: assert property ($rose(sel_n) |-> wr_n ##1 !byte_data_lines_oe)
      else $error("write end");
   a_oe_read: assert property (!oe_n |-> !sel_n && wr_n && !byte_data_lines_oe)
      else $error("output enable");
   a_wr_idle: assert property (!wr_n |-> oe_n && byte_data_lines_oe)
      else $error("write strobe idle");
endmodule
bind bnvr_host bnvr_checker #(.ACCESS_CYC(ACCESS_CYC), .PRECHARGE_CYC(PRECHARGE_CYC),
   .SEL_LOW_MAX_CYC(SEL_LOW_MAX_CYC)) u_chk (.*);

// *** verification/bnvr_fram_model.sv ***
`timescale 1ns/100ps
module bnvr_fram_model #(
   parameter int ACC_NS = 10 // Access time
) (
   input wire logic sel_n, // Select
   input wire logic wr_n, // Write strobe
   input wire logic oe_n, // Output enable
   input wire logic [12:0] addr, // Address
   input wire logic [7:0] din, // Bus level
   output logic [7:0] dq // Device data
);
   logic [7:0] mem [8192];
   logic [12:0] a_q;
   logic wr_q = 0, ok_q = 0, act_q = 0;
   always @(negedge sel_n) begin
      a_q = addr;
      wr_q = !wr_n;
      act_q = 1;
      ok_q = 0;
      #ACC_NS ok_q = 1;
   end
   always @(negedge wr_n) begin
      if (!sel_n) wr_q = 1;
   end
   always @(posedge wr_n or posedge sel_n) begin
      if (act_q && wr_q) mem[a_q] = din;
      act_q = 0;
   end
   assign dq = (!oe_n && !sel_n && ok_q && !wr_q) ? mem[a_q] : ~mem[a_q];
endmodule

// *** verification/bnvr_host_tb.sv ***
`timescale 1ns/100ps
module bnvr_host_tb;
   localparam int ACC = 3;
   logic clock = 0, rst = 1, clk_en = 1, req_valid = 0, req_write = 0;
   logic req_ready, rsp_valid, sel_n, wr_n, oe_n, byte_data_lines_oe;
   logic [12:0] req_addr = '0, byte_address_lines;
   logic [7:0] req_wdata = '0, rsp_rdata, byte_data_lines_o, byte_data_lines_i, dq, q;
   logic [15:0] row_access_count, k = '0;
   logic [9:0] last_row;
   int n_mismatch = 0, n_tests = 0;
   // Clock, resolved bus, controller, memory
   always #2 clock = ~clock;
   assign byte_data_lines_i = byte_data_lines_oe ? byte_data_lines_o : dq;
   bnvr_host #(.ACCESS_CYC(ACC), .PRECHARGE_CYC(2)) u_dut (.*);
   bnvr_fram_model u_mem (.sel_n, .wr_n, .oe_n, .addr(byte_address_lines),
      .din(byte_data_lines_i), .dq);
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      n_tests++;
      if (g !== e) begin
         n_mismatch++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask
   // One access, timed from take to done
   task automatic acc(input logic w, input logic [12:0] a, input logic [7:0] d);
      logic [15:0] n;
      n = '0;
      {req_valid, req_write, req_addr, req_wdata} = {1'b1, w, a, d};
      do @(negedge clock); while (req_ready !== 1'b1 && ++n < 16'd50);
      req_valid = 0;
      n = '0;
      do begin
         @(negedge clock);
         n++;
      end while (rsp_valid !== 1'b1 && n < 16'd50);
      k++;
      q = rsp_rdata;
      chk("delay", 16'(ACC + 1), n);
      chk("row", 16'(a[12:3]), 16'(last_row));
      chk("count", k, row_access_count);
   endtask
   task automatic t_ends;
      chk("idle", 16'h000e, {sel_n, wr_n, oe_n, byte_data_lines_oe});
      acc(1, 13'h1fff, 8'ha5);
      acc(1, 13'h0000, 8'h5a);
      acc(0, 13'h1fff, 8'h00);
      chk("top", 16'h00a5, 16'(q));
      acc(0, 13'h0000, 8'h00);
      chk("bottom", 16'h005a, 16'(q));
   endtask
   task automatic t_rows;
      acc(1, 13'h1ff8, 8'h3c);
      acc(0, 13'h1fff, 8'h00);
      chk("same row", 16'h00a5, 16'(q));
      acc(0, 13'h1ff8, 8'h00);
      chk("row start", 16'h003c, 16'(q));
   endtask
   // Clock enable low freezes a read just after its take
   task automatic t_freeze;
      logic [15:0] n;
      n = '0;
      {req_valid, req_write, req_addr} = {1'b1, 1'b0, 13'h1ff8};
      do @(negedge clock); while (req_ready !== 1'b1 && ++n < 16'd50);
      req_valid = 0;
      clk_en = 0;
      repeat (4) @(negedge clock);
      chk("frozen", 16'h0003, 16'({sel_n, req_ready}));
      chk("frozen addr", 16'h1ff8, 16'(byte_address_lines));
      clk_en = 1;
      n = '0;
      do begin
         @(negedge clock);
         n++;
      end while (rsp_valid !== 1'b1 && n < 16'd50);
      k++;
      chk("thawed delay", 16'(ACC + 1), n);
      chk("thawed read", 16'h003c, 16'(rsp_rdata));
      chk("thawed count", k, row_access_count);
   endtask
   // Reset in mid-read raises the strobes and clears the counts
   task automatic t_reset;
      logic [15:0] n;
      n = '0;
      {req_valid, req_write, req_addr} = {1'b1, 1'b0, 13'h0000};
      do @(negedge clock); while (req_ready !== 1'b1 && ++n < 16'd50);
      req_valid = 0;
      @(negedge clock);
      chk("select low", 16'h0000, 16'(sel_n));
      rst = 1;
      repeat (2) @(negedge clock);
      chk("reset pins", 16'h000e, 16'({sel_n, wr_n, oe_n, byte_data_lines_oe}));
      chk("reset count", 16'h0000, row_access_count);
      rst = 0;
      k = '0;
      acc(0, 13'h0000, 8'h00);
      chk("after reset", 16'h005a, 16'(q));
   endtask
   task automatic report_and_stop;
      $display("tests %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   // Reset, scenarios, verdict
   initial begin
      repeat (6) @(negedge clock);
      rst = 0;
      t_ends;
      t_rows;
      t_freeze;
      t_reset;
      report_and_stop;
   end
   // Hang guard
   initial begin
      repeat (1000) @(posedge clock);
      n_mismatch++;
      report_and_stop;
   end
endmodule
